// *** common/ifr_pkg.sv ***
// Package: register map, field layout, variant codes and masks of the flag block
package ifr_pkg;

    // ==========================================================
    // Device variants, smallest first
    localparam logic [2:0] IFR_VAR_A = 3'h0;
    localparam logic [2:0] IFR_VAR_B = 3'h1;
    localparam logic [2:0] IFR_VAR_C = 3'h2;
    localparam logic [2:0] IFR_VAR_D = 3'h3;
    localparam logic [2:0] IFR_VAR_E = 3'h4;

    // ==========================================================
    // Register byte offsets on the bus
    localparam logic [11:0] IFR_OFS_GROUP2 = 12'h000;
    localparam logic [11:0] IFR_OFS_GROUP3 = 12'h004;
    localparam logic [11:0] IFR_OFS_TIMER0 = 12'h008;
    localparam logic [11:0] IFR_OFS_TIMER1 = 12'h00c;
    localparam logic [11:0] IFR_OFS_PERIPH = 12'h010;
    localparam logic [11:0] IFR_OFS_CTRL   = 12'h014;
    localparam logic [11:0] IFR_OFS_STATUS = 12'h018;

    // ==========================================================
    // Reset values and fields
    localparam logic [7:0] IFR_RST_VALUE   = 8'h00;
    localparam int         IFR_CTRL_GEN    = 0;
    localparam int         IFR_STAT_PEND   = 0;
    localparam int         IFR_STAT_VEC_LO = 4;

    // Implemented bits of the group2, group3, timer0 and timer1 registers for a given variant
    function automatic logic [7:0] ifr_mask_group2(input logic [2:0] v);
        ifr_mask_group2 = (v == IFR_VAR_E) ? 8'h77 : 8'hff;
    endfunction

    function automatic logic [7:0] ifr_mask_group3(input logic [2:0] v);
        ifr_mask_group3 = (v == IFR_VAR_E) ? 8'hff : 8'h00;
    endfunction

    function automatic logic [7:0] ifr_mask_timer0(input logic [2:0] v);
        ifr_mask_timer0 = (v < IFR_VAR_C) ? 8'h33 : 8'hff;
    endfunction

    function automatic logic [7:0] ifr_mask_timer1(input logic [2:0] v);
        ifr_mask_timer1 = (v == IFR_VAR_A) ? 8'h33 : 8'h77;
    endfunction

    // Four-slot one-hot decode, used by service clears
    function automatic logic [3:0] ifr_onehot4(input logic [1:0] i);
        ifr_onehot4 = 4'h1 << i;
    endfunction

endpackage

// *** logic/ifr_flag_reg.sv ***
// One 8-bit flag/enable register with hardware set and clear
`timescale 1ns/100ps
`default_nettype none
module ifr_flag_reg #(
    parameter logic [7:0] IMPL_MASK = 8'hff
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic [3:0] hw_set,
    input  wire logic [3:0] hw_clr,
    output logic      [7:0] value
);

    logic [7:0] value_reg;
    logic [7:0] value_next;
    wire  [7:0] set_w  = {hw_set, 4'h0};
    wire  [7:0] clr_w  = {hw_clr, 4'h0};
    wire  [7:0] base_w = wr_en ? wr_data : value_reg;

    // Set applied last so an event in a clearing cycle is kept
    assign value_next = ((base_w & ~clr_w) | set_w) & IMPL_MASK;
    assign value      = value_reg;

    // ==========================================================
    // Storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_reg <= ifr_pkg::IFR_RST_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

endmodule // ifr_flag_reg
`default_nettype wire

// *** logic/ifr_irq_regs.sv ***
// Interrupt flag and enable registers for groups 2/3 and sub-registers
//
// How it works
// - Small variants: group2 MF3,TB1,TB0,MF2 plus enables
// - Largest variant: group2 MF3..MF1, bits 7,3 empty
// - Largest variant: group3 MF5,TB1,TB0,MF4 plus enables
// - Flag one means pending; enable one permits
// - Unimplemented bits always read back zero
// - Two smallest: timer0 A/P flags and enables
// - Larger three add timer2 A/P at 7,6
// - Non-smallest: timer1 adds comparator B flag/enable
// - Smallest: timer1 holds only A/P flags and enables
// - Vector only when flag, enable, global set
// - Member flag rising sets its multifunction flag
// - Service clears its flag and global enable
`timescale 1ns/100ps
`default_nettype none
module ifr_irq_regs #(
    parameter logic [2:0] VARIANT = ifr_pkg::IFR_VAR_A
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timebase0_evt,
    input  wire logic        timebase1_evt,
    input  wire logic        timer0_cmpa_evt,
    input  wire logic        timer0_cmpp_evt,
    input  wire logic        timer2_cmpa_evt,
    input  wire logic        timer2_cmpp_evt,
    input  wire logic        timer1_cmpa_evt,
    input  wire logic        timer1_cmpp_evt,
    input  wire logic        timer1_cmpb_evt,
    input  wire logic        eeprom_evt,
    input  wire logic        lowvolt_evt,
    input  wire logic        ext_periph_evt,
    input  wire logic        serial_if_evt,
    input  wire logic        multifunc3_member_evt,
    input  wire logic        multifunc4_member_evt,
    input  wire logic        multifunc5_member_evt,
    input  wire logic        svc_ack,
    input  wire logic [2:0]  svc_vector,
    output logic             irq_request,
    output logic      [2:0]  irq_vector,
    output logic             global_irq_en
);

    localparam logic [7:0] MASK_G2 = ifr_pkg::ifr_mask_group2(VARIANT);
    localparam logic [7:0] MASK_G3 = ifr_pkg::ifr_mask_group3(VARIANT);
    localparam logic [7:0] MASK_T0 = ifr_pkg::ifr_mask_timer0(VARIANT);
    localparam logic [7:0] MASK_T1 = ifr_pkg::ifr_mask_timer1(VARIANT);
    localparam logic [7:0] MASK_PE = 8'hff;
    localparam bit         LARGE   = (VARIANT == ifr_pkg::IFR_VAR_E);

    // ==========================================================
    // Bus decode
    wire setup_w  = psel & ~penable;
    wire access_w = psel & penable;
    wire wr_w     = access_w & pwrite & pstrb[0];
    wire hit_g2   = (paddr == ifr_pkg::IFR_OFS_GROUP2);
    wire hit_g3   = (paddr == ifr_pkg::IFR_OFS_GROUP3);
    wire hit_t0   = (paddr == ifr_pkg::IFR_OFS_TIMER0);
    wire hit_t1   = (paddr == ifr_pkg::IFR_OFS_TIMER1);
    wire hit_pe   = (paddr == ifr_pkg::IFR_OFS_PERIPH);
    wire hit_ct   = (paddr == ifr_pkg::IFR_OFS_CTRL);
    wire hit_st   = (paddr == ifr_pkg::IFR_OFS_STATUS);
    wire hit_any  = hit_g2 | hit_g3 | hit_t0 | hit_t1 | hit_pe | hit_ct
                  | hit_st;

    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        irq_request_reg;
    logic [2:0]  irq_vector_reg;
    logic        gen_reg;
    logic        gen_next;
    logic [3:0]  t1_prev_reg;
    logic [3:0]  pe_prev_reg;
    logic [7:0]  g2_q;
    logic [7:0]  g3_q;
    logic [7:0]  t0_q;
    logic [7:0]  t1_q;
    logic [7:0]  pe_q;
    logic        pick_valid;
    logic [2:0]  pick_idx;

    // ==========================================================
    // Multi-function sources: any newly set member flag
    wire mf2_src = |(pe_q[7:4] & ~pe_prev_reg);
    wire mf1_src = |(t1_q[7:4] & ~t1_prev_reg);

    // Group flag set vectors, bits 7..4 of each group register
    wire [3:0] g2_set_w = LARGE ?
        {1'b0, multifunc3_member_evt, mf2_src, mf1_src} :
        {multifunc3_member_evt, timebase1_evt, timebase0_evt,
         mf2_src};
    wire [3:0] g3_set_w = {multifunc5_member_evt, timebase1_evt,
                           timebase0_evt, multifunc4_member_evt};

    // Sub-register set vectors; the mask drops absent sources
    wire [3:0] t0_set_w = {timer2_cmpa_evt, timer2_cmpp_evt,
                           timer0_cmpa_evt, timer0_cmpp_evt};
    wire [3:0] t1_set_w = {1'b0, timer1_cmpb_evt,
                           timer1_cmpa_evt, timer1_cmpp_evt};
    wire [3:0] pe_set_w = {eeprom_evt, lowvolt_evt,
                           ext_periph_evt, serial_if_evt};

    // Service clears the vectored slot only
    wire [3:0] svc_hot  = ifr_pkg::ifr_onehot4(svc_vector[1:0]);
    wire [3:0] g2_clr_w = (svc_ack & ~svc_vector[2]) ? svc_hot : 4'h0;
    wire [3:0] g3_clr_w = (svc_ack &  svc_vector[2]) ? svc_hot : 4'h0;

    // ==========================================================
    // Register cells
    ifr_flag_reg #(.IMPL_MASK(MASK_G2)) u_group2 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_w & hit_g2),
        .wr_data (pwdata[7:0]),
        .hw_set  (g2_set_w),
        .hw_clr  (g2_clr_w),
        .value   (g2_q)
    );

    ifr_flag_reg #(.IMPL_MASK(MASK_G3)) u_group3 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_w & hit_g3),
        .wr_data (pwdata[7:0]),
        .hw_set  (g3_set_w),
        .hw_clr  (g3_clr_w),
        .value   (g3_q)
    );

    ifr_flag_reg #(.IMPL_MASK(MASK_T0)) u_timer0 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_w & hit_t0),
        .wr_data (pwdata[7:0]),
        .hw_set  (t0_set_w),
        .hw_clr  (4'h0),
        .value   (t0_q)
    );

    ifr_flag_reg #(.IMPL_MASK(MASK_T1)) u_timer1 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_w & hit_t1),
        .wr_data (pwdata[7:0]),
        .hw_set  (t1_set_w),
        .hw_clr  (4'h0),
        .value   (t1_q)
    );

    ifr_flag_reg #(.IMPL_MASK(MASK_PE)) u_periph (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_w & hit_pe),
        .wr_data (pwdata[7:0]),
        .hw_set  (pe_set_w),
        .hw_clr  (4'h0),
        .value   (pe_q)
    );

    // ==========================================================
    // Vector selection: a slot needs both its flag and its enable
    wire [7:0] slot_req = {g3_q[7:4] & g3_q[3:0],
                           g2_q[7:4] & g2_q[3:0]};

    ifr_vec_pick u_pick (
        .slot_req   (slot_req),
        .pick_valid (pick_valid),
        .pick_idx   (pick_idx)
    );

    // Global enable: service clear beats a software set
    assign gen_next = svc_ack ? 1'b0 :
                      (wr_w & hit_ct) ? pwdata[ifr_pkg::IFR_CTRL_GEN] :
                      gen_reg;

    // Request is held off while a service is acknowledged
    wire req_next = gen_reg & pick_valid & ~svc_ack;

    // ==========================================================
    // Read mux, captured in the setup phase
    wire [7:0] stat_w = {1'b0, irq_vector_reg, 3'h0, irq_request_reg};
    wire [7:0] rd_byte =
        hit_g2 ? g2_q :
        hit_g3 ? g3_q :
        hit_t0 ? t0_q :
        hit_t1 ? t1_q :
        hit_pe ? pe_q :
        hit_ct ? {7'h00, gen_reg} :
        hit_st ? stat_w : 8'h00;

    // Bus answer registers; zero wait, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= 1'b1;
            if (setup_w) begin
                prdata_reg  <= {24'h00_0000, rd_byte};
                pslverr_reg <= ~hit_any;
            end
        end
    end

    // Control and vectoring state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_reg         <= 1'b0;
            irq_request_reg <= 1'b0;
            irq_vector_reg  <= 3'h0;
            t1_prev_reg     <= 4'h0;
            pe_prev_reg     <= 4'h0;
        end else begin
            gen_reg         <= gen_next;
            irq_request_reg <= req_next;
            irq_vector_reg  <= pick_idx;
            t1_prev_reg     <= t1_q[7:4];
            pe_prev_reg     <= pe_q[7:4];
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign irq_request   = irq_request_reg;
    assign irq_vector    = irq_vector_reg;
    assign global_irq_en = gen_reg;

    // ==========================================================
    // Checks
    a_unimpl_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((g2_q & ~MASK_G2) == 8'h00) && ((t0_q & ~MASK_T0) == 8'h00)
        && ((t1_q & ~MASK_T1) == 8'h00) && ((g3_q & ~MASK_G3) == 8'h00))
        else $error("unimplemented bit set");

    a_global_blocks: assert property (
        @(posedge pclk) disable iff (!presetn)
        !gen_reg |=> !irq_request)
        else $error("request while global enable low");

    a_vector_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_request |-> $past(slot_req[pick_idx]) && $past(gen_reg))
        else $error("request without flag and enable");

    a_req_follows: assert property (
        @(posedge pclk) disable iff (!presetn)
        (gen_reg && pick_valid && !svc_ack) |=> irq_request)
        else $error("enabled flag raised no request");

    a_enable_blocks: assert property (
        @(posedge pclk) disable iff (!presetn)
        (gen_reg && !svc_ack && slot_req == 8'h00) |=> !irq_request)
        else $error("request with no enabled flag");

    a_mf2_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        mf2_src |=> (LARGE ? g2_q[5] : g2_q[4]))
        else $error("multifunction flag not set");

    a_svc_gen_clr: assert property (
        @(posedge pclk) disable iff (!presetn)
        svc_ack |=> !gen_reg ##1 !irq_request)
        else $error("service left global enable set");

    a_gen_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_w && hit_ct && !svc_ack)
        |=> gen_reg == $past(pwdata[ifr_pkg::IFR_CTRL_GEN]))
        else $error("global enable write not stored");

    a_svc_flag_clr: assert property (
        @(posedge pclk) disable iff (!presetn)
        (svc_ack && !svc_vector[2] && !(wr_w && hit_g2)
         && (g2_set_w & svc_hot) == 4'h0 && MASK_G2[svc_vector[1:0] + 4])
        |=> !g2_q[$past(svc_vector[1:0]) + 4])
        else $error("serviced flag not cleared");

    a_timebase_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        (timebase0_evt && !LARGE) |=> g2_q[5])
        else $error("time base flag missed");

    a_write_lands: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_w && hit_pe && pe_set_w == 4'h0) |=> pe_q == $past(pwdata[7:0]))
        else $error("software write not stored");

    a_t1_write_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_w && hit_t1 && t1_set_w == 4'h0)
        |=> t1_q == ($past(pwdata[7:0]) & MASK_T1))
        else $error("timer1 write not stored");

    // No hardware clear on sub-registers, so only a write may drop a flag
    a_flag_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        (t0_q[4] && !(wr_w && hit_t0)) |=> t0_q[4])
        else $error("pending flag dropped");

endmodule // ifr_irq_regs
`default_nettype wire

// *** logic/ifr_vec_pick.sv ***
// Fixed-priority picker over the eight vector slots, lowest slot first
`timescale 1ns/100ps
`default_nettype none
module ifr_vec_pick (
    input  wire logic [7:0] slot_req,
    output logic            pick_valid,
    output logic      [2:0] pick_idx
);

    // Scan from the top down so the lowest requesting slot wins
    always_comb begin
        pick_idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (slot_req[i]) begin
                pick_idx = 3'(i);
            end
        end
    end

    assign pick_valid = |slot_req;

endmodule // ifr_vec_pick
`default_nettype wire

// *** tb/ifr_far_end.sv ***
// Far-side model: on-chip event sources and the vectoring CPU core
`timescale 1ns/100ps
`default_nettype none
module ifr_far_end (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] fire,
    input  wire logic        ack_on,
    input  wire logic        irq_request,
    input  wire logic [2:0]  irq_vector,
    output logic      [15:0] evt,
    output logic             svc_ack,
    output logic      [2:0]  svc_vector,
    output logic      [2:0]  last_vec,
    output logic      [7:0]  ack_count
);
    // ==========================================================
    // Sources pulse one cycle; the core answers a request a cycle late
    // and never twice running, so a request still high during its own
    // service is not taken a second time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt        <= 16'h0000;
            svc_ack    <= 1'b0;
            svc_vector <= 3'h0;
            last_vec   <= 3'h0;
            ack_count  <= 8'h00;
        end else begin
            evt        <= fire;
            svc_ack    <= ack_on & irq_request & ~svc_ack;
            svc_vector <= irq_vector;
            if (svc_ack) begin
                last_vec  <= svc_vector;
                ack_count <= ack_count + 8'h01;
            end
        end
    end
endmodule // ifr_far_end
`default_nettype wire

// *** tb/tb_interrupt_flag_enable_regs.sv ***
// Self-checking bench for the flag/enable register block
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_flag_enable_regs;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [15:0] fire, evt;
    logic        ack_on, svc_ack, irq_request, global_irq_en;
    logic [2:0]  svc_vector, irq_vector, last_vec;
    logic [7:0]  ack_count;
    int          n_mismatch, cmp_count;
    // ==========================================================
    // Register map and per-event landing place of the flag
    localparam logic [11:0] ROFS [5] = '{12'h000, 12'h004, 12'h008,
                                         12'h00c, 12'h010};
    localparam logic [7:0]  RMSK [5] = '{8'hff, 8'h00, 8'hff, 8'h77, 8'hff};
    localparam logic [11:0] EOFS [16] = '{12'h000, 12'h000, 12'h008,
        12'h008, 12'h008, 12'h008, 12'h00c, 12'h00c, 12'h00c, 12'h010,
        12'h010, 12'h010, 12'h010, 12'h000, 12'h004, 12'h004};
    localparam logic [7:0]  EEXP [16] = '{8'h20, 8'h40, 8'h20, 8'h10,
        8'h80, 8'h40, 8'h20, 8'h10, 8'h40, 8'h80, 8'h40, 8'h20, 8'h10,
        8'h80, 8'h00, 8'h00};
    localparam logic [11:0] G2 = ifr_pkg::IFR_OFS_GROUP2;
    localparam logic [11:0] CT = ifr_pkg::IFR_OFS_CTRL;
    localparam logic [11:0] ST = ifr_pkg::IFR_OFS_STATUS;

    // ==========================================================
    // Design and far side
    ifr_irq_regs #(.VARIANT(ifr_pkg::IFR_VAR_C)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timebase0_evt(evt[0]), .timebase1_evt(evt[1]),
        .timer0_cmpa_evt(evt[2]), .timer0_cmpp_evt(evt[3]),
        .timer2_cmpa_evt(evt[4]), .timer2_cmpp_evt(evt[5]),
        .timer1_cmpa_evt(evt[6]), .timer1_cmpp_evt(evt[7]),
        .timer1_cmpb_evt(evt[8]), .eeprom_evt(evt[9]),
        .lowvolt_evt(evt[10]), .ext_periph_evt(evt[11]),
        .serial_if_evt(evt[12]), .multifunc3_member_evt(evt[13]),
        .multifunc4_member_evt(evt[14]), .multifunc5_member_evt(evt[15]),
        .svc_ack(svc_ack), .svc_vector(svc_vector),
        .irq_request(irq_request), .irq_vector(irq_vector),
        .global_irq_en(global_irq_en));
    ifr_far_end far (
        .pclk(pclk), .presetn(presetn), .fire(fire), .ack_on(ack_on),
        .irq_request(irq_request), .irq_vector(irq_vector), .evt(evt),
        .svc_ack(svc_ack), .svc_vector(svc_vector), .last_vec(last_vec),
        .ack_count(ack_count));

    // Free-running 50 MHz clock
    always #10 pclk = ~pclk;

    // ==========================================================
    // Shared tasks: verdict, compare, bus cycle, event pulse
    task automatic end_sim;
        $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Held until pready is seen; data taken at that same edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never reassigns psel now
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {24'h0, d}, q, e);
    endtask
    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [7:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, {24'h0, x}, q);
    endtask
    // Flag lands two edges after the request, its group flag one later
    task automatic pulse(input int i);
        fire <= 16'h0001 << i;
        @(posedge pclk);
        fire <= 16'h0000;
        repeat (4) @(posedge pclk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        for (int i = 0; i < 5; i++) rd("reset reg", ROFS[i], 8'h00);
        rd("reset ctrl", CT, 8'h00);
        chk("reset irq", 32'h0, {31'h0, irq_request});
    endtask
    task automatic t_rw;
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 5; i++) begin
            wr(ROFS[i], 8'hff);
            rd("all ones", ROFS[i], RMSK[i]);
            wr(ROFS[i], 8'h00);
            rd("all zeros", ROFS[i], 8'h00);
        end
        // Writing ones to the peripheral flags raised the group flag too
        rd("mf2 by write", G2, 8'h10);
        wr(G2, 8'h00);
        apb(1'b0, 12'h01c, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
    endtask
    task automatic t_events;
        for (int i = 0; i < 16; i++) begin
            pulse(i);
            rd("event flag", EOFS[i], EEXP[i]);
            if (i >= 9 && i <= 12) rd("group flag", G2, 8'h10);
            wr(EOFS[i], 8'h00);
            wr(G2, 8'h00);
        end
    endtask
    task automatic t_vector;
        logic [7:0] n0;
        wr(CT, 8'h01);
        wr(G2, 8'h20);
        repeat (3) @(posedge pclk);
        chk("masked irq", 32'h0, {31'h0, irq_request});
        wr(G2, 8'h33);
        repeat (3) @(posedge pclk);
        rd("lowest slot", ST, 8'h01);
        wr(G2, 8'h22);
        repeat (3) @(posedge pclk);
        rd("status", ST, 8'h11);
        n0 = ack_count;
        ack_on <= 1'b1;
        for (int k = 0; k < 20 && ack_count === n0; k++) @(posedge pclk);
        ack_on <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("serviced vec", 32'h1, {29'h0, last_vec});
        chk("global en", 32'h0, {31'h0, global_irq_en});
        rd("flag cleared", G2, 8'h02);
        rd("ctrl cleared", CT, 8'h00);
        pulse(0);
        chk("blocked irq", 32'h0, {31'h0, irq_request});
        rd("recorded", G2, 8'h22);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        fire = 16'h0000;
        ack_on = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_rw;
        t_events;
        t_vector;
        end_sim;
    end
    // Whole run is under 1000 cycles; this allows ten times that
    initial begin
        #200000;
        n_mismatch++;
        end_sim;
    end
endmodule // tb_interrupt_flag_enable_regs
`default_nettype wire
